// ---- verilog/adc_spi_command_crc_interface.sv ----
// Command decode, register file and CRC checking of the converter serial port.
// Assumes the host leaves chip select high for a few system clocks between frames.
`timescale 1ns/1ps
`default_nettype none

module adc_spi_command_crc_interface #(
    parameter int NUM_REGS = adc_spi_pkg::NUM_REGS
) (
    // System clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // Serial link
    input  wire logic        sclk,
    input  wire logic        csN,
    input  wire logic        sdi,
    output var  logic        sdoOut,
    output var  logic        sdoOeN,
    // Conversion data
    input  wire logic [23:0] convData,
    input  wire logic        convReady,
    // Configuration and status
    output var  logic        crcEnable,
    output var  logic        dataMode16,
    output var  logic        statusEnable,
    output var  logic        linkError,
    output var  logic        readPending
);

    // ************************************************************
    // Helpers
    // ************************************************************
    // Upper nibble of the first command byte picks the command
    function automatic logic cmdIs(input logic [7:0] b, input logic [3:0] code);
        return b[7:4] == code;
    endfunction : cmdIs

    // ************************************************************
    // Frame phase
    // ************************************************************
    // Decode waits one clock past the synced edge; frames are far apart
    typedef enum logic [1:0] {
        PH_IDLE   = 2'b00,
        PH_ACTIVE = 2'b01,
        PH_END    = 2'b10
    } framePhase_t;

    // ************************************************************
    // Declarations
    // ************************************************************
    framePhase_t phase;
    framePhase_t next_phase;
    logic [7:0]  regs [NUM_REGS];
    logic        csSync1;
    logic        csSync2;
    logic [23:0] cmdShift;
    logic [39:0] frameWord;
    logic        prevCrcErr;
    logic        dataNew;
    logic [7:0]  readData;

    wire         frameEnd;
    wire  [7:0]  cmdByte1;
    wire  [7:0]  cmdByte2;
    wire  [7:0]  crcIn;
    wire  [7:0]  crcCalc;
    wire         crcGood;
    wire  [3:0]  cmdAddr;
    wire         addrValid;
    wire         isRead;
    wire         isWrite;
    wire         readOk;
    wire         readRefused;
    wire         writeOk;
    wire         regWrite;
    wire         errSet;
    wire         errClear;
    wire  [7:0]  statusByte;
    wire  [7:0]  regValue;
    wire  [23:0] payload24;
    wire  [15:0] payload16;
    wire  [31:0] body;
    wire  [2:0]  nBytes;
    wire  [7:0]  crcOut;
    wire  [5:0]  crcShift;
    wire  [39:0] next_frameWord;
    wire         next_linkError;
    wire         next_dataNew;
    wire  [31:0] bodyStat24;
    wire  [31:0] bodyStat16;
    wire  [31:0] bodyPlain24;
    wire  [31:0] bodyPlain16;
    wire  [39:0] frameNoCrc;
    wire  [39:0] crcPlaced;
    wire         isStatusAddr;
    wire  [7:0]  newBit;
    wire  [7:0]  errBit;

    // ************************************************************
    // Link-side shifter
    // ************************************************************
    spi_link_shifter linkShifter (
        .sclk      (sclk),
        .csN       (csN),
        .sdi       (sdi),
        .sdoOut    (sdoOut),
        .sdoOeN    (sdoOeN),
        .frameWord (frameWord),
        .cmdShift  (cmdShift)
    );

    // ************************************************************
    // Chip select crossing
    // ************************************************************
    // The first stage feeds nothing but the second
    always_ff @(posedge clk) begin
        if (rst) begin
            csSync1 <= 1'b1;
            csSync2 <= 1'b1;
        end else begin
            csSync1 <= csN;
            csSync2 <= csSync1;
        end
    end

    // Reset leaves the phase idle, matching chip select high: no false end
    always_ff @(posedge clk) begin
        if (rst) begin
            phase <= PH_IDLE;
        end else begin
            phase <= next_phase;
        end
    end

    always_comb begin
        next_phase = phase;
        case (phase)
            PH_IDLE: begin
                if (!csSync2) begin
                    next_phase = PH_ACTIVE;
                end
            end
            PH_ACTIVE: begin
                if (csSync2) begin
                    next_phase = PH_END;
                end
            end
            PH_END: begin
                next_phase = PH_IDLE;
            end
            default: begin
                next_phase = PH_IDLE;
            end
        endcase
    end

    // Shift register is static once chip select is high, so it is read directly
    assign frameEnd = phase == PH_END;

    // ************************************************************
    // Command decode
    // ************************************************************
    assign crcEnable    = regs[adc_spi_pkg::ADDR_SETUP4][adc_spi_pkg::SETUP4_CRC_BIT];
    assign dataMode16   = regs[adc_spi_pkg::ADDR_SETUP4][adc_spi_pkg::SETUP4_RES16_BIT];
    assign statusEnable = regs[adc_spi_pkg::ADDR_SETUP4][adc_spi_pkg::SETUP4_STATUS_BIT];

    assign cmdByte1 = crcEnable ? cmdShift[23:16] : cmdShift[15:8];
    assign cmdByte2 = crcEnable ? cmdShift[15:8]  : cmdShift[7:0];
    assign crcIn    = cmdShift[7:0];

    // Both command bytes enter the check, whatever the second holds
    assign crcCalc = adc_spi_pkg::crc8({cmdByte1, cmdByte2, 16'h0000}, 3'h2);
    assign crcGood = ~crcEnable | (crcCalc == crcIn);

    assign cmdAddr   = cmdByte1[3:0];
    assign addrValid = {1'b0, cmdAddr} < 5'(NUM_REGS);
    assign isRead    = cmdIs(cmdByte1, adc_spi_pkg::CMD_READ);
    assign isWrite   = cmdIs(cmdByte1, adc_spi_pkg::CMD_WRITE);

    assign isStatusAddr = cmdAddr == adc_spi_pkg::ADDR_STATUS;

    // ************************************************************
    // Command execution
    // ************************************************************
    assign readOk      = frameEnd & crcGood & isRead & ~prevCrcErr;
    assign readRefused = frameEnd & crcGood & isRead & prevCrcErr;
    assign writeOk     = frameEnd & crcGood & isWrite & addrValid
                         & (~linkError | isStatusAddr);
    assign regWrite    = writeOk & ~isStatusAddr;
    assign errClear    = writeOk & isStatusAddr
                         & cmdByte2[adc_spi_pkg::STATUS_ERR_BIT];
    assign errSet      = frameEnd & (~crcGood | readRefused);

    // Setting wins over a clear landing in the same cycle
    assign next_linkError = errSet | (linkError & ~errClear);

    // New-data flag drops once a conversion frame has been shifted out
    assign next_dataNew = convReady | (dataNew & ~(frameEnd & ~readPending));

    // ************************************************************
    // Status byte
    // ************************************************************
    assign newBit     = dataNew ? (8'h01 << adc_spi_pkg::STATUS_NEW_BIT) : 8'h00;
    assign errBit     = linkError ? (8'h01 << adc_spi_pkg::STATUS_ERR_BIT) : 8'h00;
    assign statusByte = newBit | errBit;

    assign regValue = !addrValid ? 8'h00 :
                      isStatusAddr ? statusByte :
                      regs[cmdAddr];

    always_ff @(posedge clk) begin
        if (rst) begin
            linkError <= 1'b0;
        end else begin
            linkError <= next_linkError;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            dataNew <= 1'b0;
        end else begin
            dataNew <= next_dataNew;
        end
    end

    // Only the command just decoded decides whether the next read is refused
    always_ff @(posedge clk) begin
        if (rst) begin
            prevCrcErr <= 1'b0;
        end else if (frameEnd) begin
            prevCrcErr <= ~crcGood;
        end
    end

    // Response is latched now and shown in the following frame
    always_ff @(posedge clk) begin
        if (rst) begin
            readPending <= 1'b0;
        end else if (frameEnd) begin
            readPending <= readOk;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            readData <= 8'h00;
        end else if (readOk) begin
            readData <= regValue;
        end
    end

    // ************************************************************
    // Register file
    // ************************************************************
    always_ff @(posedge clk) begin
        if (rst) begin
            for (int i = 0; i < NUM_REGS; i++) begin
                regs[i] <= adc_spi_pkg::REG_RESET;
            end
        end else if (regWrite) begin
            regs[cmdAddr] <= cmdByte2;
        end
    end

    // ************************************************************
    // Output frame assembly
    // ************************************************************
    // Register byte plus zero pads fills exactly the data slot
    assign payload24 = readPending ? {readData, 16'h0000} : convData;
    assign payload16 = readPending ? {readData, 8'h00} : convData[23:8];

    assign bodyStat24  = {statusByte, payload24};
    assign bodyStat16  = {statusByte, payload16, 8'h00};
    assign bodyPlain24 = {payload24, 8'h00};
    assign bodyPlain16 = {payload16, 16'h0000};

    // Body bytes left aligned, unused tail bytes zero
    assign body = statusEnable ?
                  (dataMode16 ? bodyStat16 : bodyStat24) :
                  (dataMode16 ? bodyPlain16 : bodyPlain24);

    assign nBytes = 3'h2 + (dataMode16 ? 3'h0 : 3'h1) + (statusEnable ? 3'h1 : 3'h0);

    assign crcOut   = adc_spi_pkg::crc8(body, nBytes);
    assign crcShift = {3'(3'h4 - nBytes), 3'b000};

    assign frameNoCrc = {body, 8'h00};
    assign crcPlaced  = {32'h0000_0000, crcOut} << crcShift;

    // CRC lands right after the last body byte
    assign next_frameWord = crcEnable ? (frameNoCrc | crcPlaced) : frameNoCrc;

    // Frozen while a frame runs; the link side reads it during the frame
    always_ff @(posedge clk) begin
        if (rst) begin
            frameWord <= 40'h00_0000_0000;
        end else if (csSync2) begin
            frameWord <= next_frameWord;
        end
    end

endmodule : adc_spi_command_crc_interface

`default_nettype wire

// ---- verilog/adc_spi_pkg.sv ----
// Constants and the CRC-8 function shared by the serial command port.
// Assumes an 8-bit register map addressed by a 4-bit field in the command.
package adc_spi_pkg;

    // ************************************************************
    // Command encoding
    // ************************************************************
    localparam logic [3:0] CMD_READ    = 4'h4;
    localparam logic [3:0] CMD_WRITE   = 4'h8;

    // ************************************************************
    // Register map
    // ************************************************************
    localparam logic [3:0] ADDR_STATUS = 4'h1;
    localparam logic [3:0] ADDR_SETUP4 = 4'h4;
    localparam int         NUM_REGS    = 10;
    localparam logic [7:0] REG_RESET   = 8'h00;

    // Fourth setup register fields
    localparam int SETUP4_CRC_BIT    = 0;
    localparam int SETUP4_RES16_BIT  = 1;
    localparam int SETUP4_STATUS_BIT = 2;

    // Status byte fields
    localparam int STATUS_ERR_BIT    = 6;
    localparam int STATUS_NEW_BIT    = 7;

    // ************************************************************
    // Framing
    // ************************************************************
    localparam int FRAME_BITS = 40;
    localparam int CMD_BITS   = 24;
    localparam int SYNC_STAGES = 2;

    // ************************************************************
    // CRC
    // ************************************************************
    localparam logic [7:0] CRC_POLY = 8'h07;
    localparam logic [7:0] CRC_INIT = 8'hFF;

    // Bytes are left aligned in arg and fed MSB first
    function automatic logic [7:0] crc8(input logic [31:0] arg, input logic [2:0] nBytes);
        logic [7:0] c;
        logic       fb;
        int         lowBit;
        c      = CRC_INIT;
        fb     = 1'b0;
        lowBit = 32 - 8 * int'(nBytes);
        for (int i = 31; i >= 0; i--) begin
            if (i >= lowBit) begin
                fb = c[7] ^ arg[i];
                c  = {c[6:0], 1'b0};
                if (fb) begin
                    c = c ^ CRC_POLY;
                end
            end
        end
        return c;
    endfunction : crc8

endpackage : adc_spi_pkg

// ---- verilog/spi_link_shifter.sv ----
// Serial-clock side of the port: input shift register and output shifter.
// Assumes sclk idles low and stands still while chip select is high.
`timescale 1ns/1ps
`default_nettype none

module spi_link_shifter (
    // Link pins
    input  wire logic        sclk,
    input  wire logic        csN,
    input  wire logic        sdi,
    output var  logic        sdoOut,
    output var  logic        sdoOeN,
    // Frame exchange with the system domain
    input  wire logic [39:0] frameWord,
    output var  logic [23:0] cmdShift
);

    logic [5:0] bitIdx;

    // ************************************************************
    // Input capture
    // ************************************************************
    // Only the last bits survive, so leading pad bytes fall out
    always_ff @(negedge sclk) begin
        if (!csN) begin
            cmdShift <= {cmdShift[adc_spi_pkg::CMD_BITS-2:0], sdi};
        end
    end

    // ************************************************************
    // Output shifting
    // ************************************************************
    // Chip select itself ends the frame; no sclk edge comes after it
    always_ff @(posedge sclk or posedge csN) begin
        if (csN) begin
            bitIdx <= 6'h00;
            sdoOut <= 1'b0;
            sdoOeN <= 1'b1;
        end else begin
            sdoOeN <= 1'b0;
            if (bitIdx < 6'(adc_spi_pkg::FRAME_BITS)) begin
                sdoOut <= frameWord[6'(adc_spi_pkg::FRAME_BITS - 1) - bitIdx];
                bitIdx <= bitIdx + 6'h01;
            end else begin
                sdoOut <= 1'b0;
            end
        end
    end

endmodule : spi_link_shifter

`default_nettype wire

// ---- tb/host_spi_model.sv ----
// Host controller model for the converter serial port, mode 1 framing.
// Assumes the caller spaces frames; this model leaves 600 ns of idle after each.
`timescale 1ns/1ps
`default_nettype none

module host_spi_model (
    // Link pins
    output var  logic sclk,
    output var  logic csN,
    output var  logic sdi,
    input  wire logic sdoOut,
    input  wire logic sdoOeN
);
    initial begin
        sclk = 1'b0;
        csN  = 1'b1;
        sdi  = 1'b0;
    end

    // ************************************************************
    // CRC over n right-aligned bytes
    // ************************************************************
    function automatic logic [7:0] crc(input logic [31:0] a, input int n);
        logic [7:0] c;
        c = 8'hFF;
        for (int i = 8 * n - 1; i >= 0; i--) begin
            c = {c[6:0], 1'b0} ^ ((c[7] ^ a[i]) ? 8'h07 : 8'h00);
        end
        return c;
    endfunction : crc

    // ************************************************************
    // One frame, MSB first, read back on falling edges
    // ************************************************************
    task automatic frame(input logic [39:0] tx, input int n, output logic [39:0] rx);
        rx  = 40'h0000000000;
        csN = 1'b0;
        #400;
        // Data moves on the rising edge so it is settled at the falling one
        for (int i = n - 1; i >= 0; i--) begin
            #7.5 sclk = 1'b1;
            sdi = tx[i];
            #7.5 rx = {rx[38:0], sdoOut};
            sclk = 1'b0;
        end
        // Whole frames only, never cut short
        #10 csN = 1'b1;
        sdi = ~sdi;
        #600;
    endtask : frame

endmodule : host_spi_model
`default_nettype wire

// ---- tb/adc_spi_command_crc_interface_sva.sv ----
// Checker of the serial command port, watching the top module's ports only.
// Assumes csN is held high during reset.
`timescale 1ns/1ps
`default_nettype none

module adc_spi_checker #(
    parameter int NUM_REGS = 10
) (
    // Clock, reset
    input wire logic        clk,
    input wire logic        rst,
    // Link
    input wire logic        sclk,
    input wire logic        csN,
    input wire logic        sdi,
    input wire logic        sdoOut,
    input wire logic        sdoOeN,
    // Data and status
    input wire logic [23:0] convData,
    input wire logic        convReady,
    input wire logic        crcEnable,
    input wire logic        dataMode16,
    input wire logic        statusEnable,
    input wire logic        linkError,
    input wire logic        readPending
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    cfg_reset_a: assert property (disable iff (1'b0) rst |=> !crcEnable && !dataMode16
        && !statusEnable && !linkError && !readPending) else $error("state not cleared by reset");
    quiet_oe_a: assert property (csN |-> sdoOeN) else $error("output driven off frame");
    quiet_sdo_a: assert property (csN && $past(csN) |-> !sdoOut) else $error("idle data high");
    frame_hold_a: assert property (!csN [*4] |-> $stable(linkError) && $stable(readPending)
        && $stable(crcEnable)) else $error("state changed inside frame");
    err_set_a: assert property ($rose(linkError) |-> csN && $past(csN))
        else $error("error flag set inside frame");
    err_clear_a: assert property ($fell(linkError) |-> csN && $past(csN))
        else $error("error flag cleared inside frame");
    pend_set_a: assert property ($rose(readPending) |-> csN && $past(csN))
        else $error("response armed inside frame");
    pend_clear_a: assert property ($fell(readPending) |-> csN) else $error("response lost");
    mode_keep_a: assert property (!$stable(dataMode16) || !$stable(statusEnable) |-> csN)
        else $error("setup changed inside frame");

    cover property ($rose(linkError));
    cover property ($rose(readPending) && linkError);
    cover property ($fell(linkError));
endmodule : adc_spi_checker

bind adc_spi_command_crc_interface adc_spi_checker #(.NUM_REGS(NUM_REGS)) i_chk (
    .clk(clk), .rst(rst), .sclk(sclk), .csN(csN), .sdi(sdi), .sdoOut(sdoOut),
    .sdoOeN(sdoOeN), .convData(convData), .convReady(convReady), .crcEnable(crcEnable),
    .dataMode16(dataMode16), .statusEnable(statusEnable), .linkError(linkError),
    .readPending(readPending));
`default_nettype wire

// ---- tb/adc_spi_command_crc_interface_tb.sv ----
// Self-checking bench of the serial command port with a host model.
// Assumes the design package and modules are compiled first.
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, exp, got) begin \
    numChecks++; \
    if ((got) !== (exp)) begin \
        errTotal++; \
        $display("[FAIL] %s expected %0h seen %0h", nm, exp, got); \
    end \
end

module adc_spi_command_crc_interface_tb;
    logic        clk;
    logic        rst;
    logic        sclk;
    logic        csN;
    logic        sdi;
    logic        sdoOut;
    logic        sdoOeN;
    logic [23:0] convData;
    logic        convReady;
    logic        crcEnable;
    logic        dataMode16;
    logic        statusEnable;
    logic        linkError;
    logic        readPending;
    logic        crcOn;
    logic [39:0] rx;
    int          errTotal;
    int          numChecks;

    adc_spi_command_crc_interface i_dut (
        .clk(clk), .rst(rst), .sclk(sclk), .csN(csN), .sdi(sdi), .sdoOut(sdoOut),
        .sdoOeN(sdoOeN), .convData(convData), .convReady(convReady),
        .crcEnable(crcEnable), .dataMode16(dataMode16), .statusEnable(statusEnable),
        .linkError(linkError), .readPending(readPending));
    host_spi_model i_host (.sclk(sclk), .csN(csN), .sdi(sdi), .sdoOut(sdoOut),
        .sdoOeN(sdoOeN));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic printVerdict();
        $display("checks %0d mismatches %0d", numChecks, errTotal);
        if (errTotal == 0 && numChecks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : printVerdict

    // Command plus optional check byte, zero padded in front
    task automatic xfer(input logic [7:0] b1, input logic [7:0] b2, input logic bad, input int n);
        logic [7:0] c;
        c = bad ? 8'h00 : i_host.crc({16'h0000, b1, b2}, 2);
        if (crcOn) begin
            i_host.frame({16'h0000, b1, b2, c}, n, rx);
        end else begin
            i_host.frame({24'h000000, b1, b2}, n, rx);
        end
    endtask : xfer

    task automatic t_reset();
        `CHK("crcEnable", 1'b0, crcEnable);
        `CHK("linkError", 1'b0, linkError);
        `CHK("readPending", 1'b0, readPending);
        `CHK("sdoOeN", 1'b1, sdoOeN);
        $display("test reset done");
    endtask : t_reset

    task automatic t_basic();
        xfer(8'h84, 8'h02, 1'b0, 24);
        `CHK("dataMode16", 1'b1, dataMode16);
        xfer(8'h83, 8'hA5, 1'b0, 16);
        xfer(8'h43, 8'h00, 1'b0, 16);
        `CHK("readPending", 1'b1, readPending);
        xfer(8'h4C, 8'hFF, 1'b0, 16);
        `CHK("regByte", 16'hA500, rx[15:0]);
        xfer(8'h00, 8'h00, 1'b0, 16);
        `CHK("outOfRange", 16'h0000, rx[15:0]);
        `CHK("readPending", 1'b0, readPending);
        $display("test basic done");
    endtask : t_basic

    task automatic t_crc();
        xfer(8'h84, 8'h05, 1'b0, 16);
        `CHK("crcEnable", 1'b1, crcEnable);
        `CHK("statusEnable", 1'b1, statusEnable);
        crcOn = 1'b1;
        `CHK("noopCrc", 8'hD7, i_host.crc(32'h00000000, 2));
        xfer(8'h43, 8'h77, 1'b0, 40);
        `CHK("readPending", 1'b1, readPending);
        xfer(8'h00, 8'h00, 1'b0, 40);
        `CHK("respBody", 24'hA50000, rx[31:8]);
        `CHK("respCrc", i_host.crc(rx[39:8], 4), rx[7:0]);
        `CHK("linkError", 1'b0, linkError);
        $display("test crc done");
    endtask : t_crc

    task automatic t_error();
        xfer(8'h00, 8'h00, 1'b1, 40);
        `CHK("linkError", 1'b1, linkError);
        xfer(8'h43, 8'h00, 1'b0, 40);
        `CHK("readPending", 1'b0, readPending);
        `CHK("convWord", convData, rx[31:8]);
        `CHK("statusErr", 1'b1, rx[38]);
        `CHK("convCrc", i_host.crc(rx[39:8], 4), rx[7:0]);
        xfer(8'h83, 8'h3C, 1'b0, 40);
        xfer(8'h43, 8'h00, 1'b0, 40);
        `CHK("readPending", 1'b1, readPending);
        xfer(8'h81, 8'h40, 1'b0, 40);
        `CHK("regKept", 24'hA50000, rx[31:8]);
        `CHK("linkError", 1'b0, linkError);
        $display("test error done");
    endtask : t_error

    // Tests need about 20 us
    initial begin
        #200000;
        errTotal++;
        printVerdict();
    end

    initial begin
        rst       = 1'b1;
        convData  = 24'h000000;
        convReady = 1'b0;
        crcOn     = 1'b0;
        errTotal  = 0;
        numChecks = 0;
        repeat (4) @(posedge clk);
        rst       <= 1'b0;
        convData  <= 24'h3C5A69;
        convReady <= 1'b1;
        @(posedge clk);
        convReady <= 1'b0;
        repeat (6) @(posedge clk);
        t_reset();
        t_basic();
        t_crc();
        t_error();
        printVerdict();
    end
endmodule : adc_spi_command_crc_interface_tb
`default_nettype wire
